// ==== hdl/hpc_port.sv ====
// Host port pin control: strobes, address latch, ready, interrupt pin.
// Assumes a core memory side that answers each request with core_done.
// Operation
// - Data strobes from host time and control each transfer.
// - Address strobe falling edge latches presented byte into address.
// - Direction input level chooses read or write per transfer.
// - Ready tells host when the next transfer may start.
// - Interrupt pin driven high while in reset, interrupts host otherwise.
// - Disabled port hands interrupt pin to the timer one output.
// - Strap sampled at reset release and latched as enabled state.
// - Low or floating strap during reset disables the port.
// - Strap ignored after that until the next reset.
// - Input pull-ups enabled only when the strap reads zero.
// - Ready pin, and interrupt pin outside reset, float while emulation-off is low.
// - Register select inputs steer access to one of three registers.
// - Byte half select marks first or second byte of a word.
// - Data bus floats unless driving read data with emulation-off high.
`timescale 1ns/1ps
module hpc_port import hpc_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic port_select_n,
  input wire logic xfer_strobe_a,
  input wire logic xfer_strobe_b,
  input wire logic addr_latch_n,
  input wire logic xfer_direction,
  input wire logic reg_select_lo,
  input wire logic reg_select_hi,
  input wire logic byte_half_select,
  input wire logic [7:0] host_data_in,
  input wire logic port_enable_strap,
  input wire logic emu_float_n,
  input wire logic timer_one_in,
  input wire logic core_irq_set,
  input wire logic core_done,
  input wire logic [15:0] core_rdata,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  output logic port_ready_out,
  output logic port_ready_oe,
  output logic host_irq_out,
  output logic host_irq_oe,
  output logic pullup_en,
  output logic port_enabled,
  output hpc_req_t core_req
);
  hpc_pins_t pins_raw;
  hpc_pins_t pins;
  logic [$bits(hpc_pins_t)-1:0] pins_q;
  hpc_state_t st;
  hpc_state_t next_st;
  logic stb_act;
  logic stb_start;
  logic stb_end;
  logic as_fall;
  logic rd_now;
  logic [1:0] sel;

  // Pick one byte of a word by half select
  function automatic logic [7:0] get_byte(input logic [15:0] w,
                                          input logic bil);
    get_byte = (bil == HPC_BIL_FIRST) ? w[15:8] : w[7:0];
  endfunction

  // Replace one byte of a word by half select
  function automatic logic [15:0] put_byte(input logic [15:0] w,
                                           input logic bil,
                                           input logic [7:0] b);
    put_byte = (bil == HPC_BIL_FIRST) ? {b, w[7:0]} : {w[15:8], b};
  endfunction

  // Pins pass two flops before use
  assign pins_raw = '{cs_n: port_select_n, ds_a: xfer_strobe_a,
                      ds_b: xfer_strobe_b, as_n: addr_latch_n,
                      dir: xfer_direction, sel_hi: reg_select_hi,
                      sel_lo: reg_select_lo, bil: byte_half_select,
                      strap: port_enable_strap, emu_n: emu_float_n,
                      data: host_data_in};

  hpc_sync #(.W($bits(hpc_pins_t))) u_sync (
    .clk_sys(clk_sys),
    .d(pins_raw),
    .q(pins_q)
  );
  assign pins = hpc_pins_t'(pins_q);

  // Access window and its edges
  assign sel = {pins.sel_hi, pins.sel_lo};
  assign stb_act = st.enabled && !pins.cs_n &&
                   (!pins.ds_a || !pins.ds_b);
  assign stb_start = stb_act && !st.stb_d;
  assign stb_end = !stb_act && st.stb_d;
  assign as_fall = st.enabled && !pins.as_n && st.as_d;
  assign rd_now = stb_act && (pins.dir == HPC_DIR_READ);

  // Next state of the whole port
  always_comb begin
    next_st = st;
    next_st.in_reset = 1'b0;
    next_st.stb_d = stb_act;
    next_st.as_d = pins.as_n;
    if (st.in_reset) begin
      next_st.enabled = pins.strap;
    end
    if (as_fall) begin
      next_st.addr = put_byte(st.addr, pins.bil, pins.data);
    end
    // Strobe start: note the access, take write bytes
    if (stb_start) begin
      next_st.op_sel = sel;
      next_st.op_read = (pins.dir == HPC_DIR_READ);
      next_st.op_bil = pins.bil;
      if (pins.dir != HPC_DIR_READ) begin
        case (sel)
          HPC_SEL_ADDR: begin
            next_st.addr = put_byte(st.addr, pins.bil, pins.data);
          end
          HPC_SEL_CTL: begin
            if (pins.bil != HPC_BIL_FIRST &&
                pins.data[HPC_CTL_IRQ_BIT]) begin
              next_st.ctl_irq = 1'b0;
            end
          end
          default: begin
            if (pins.bil == HPC_BIL_FIRST) begin
              next_st.wlatch = pins.data;
            end else begin
              next_st.wword = {st.wlatch, pins.data};
            end
          end
        endcase
      end
    end
    // Core answer ends the internal transfer
    if (st.req.valid && core_done) begin
      next_st.req.valid = 1'b0;
      if (!st.req.write) begin
        next_st.rbuf = core_rdata;
      end
    end
    // Strobe end: launch the internal transfer
    if (stb_end && st.op_bil != HPC_BIL_FIRST) begin
      case (st.op_sel)
        HPC_SEL_DATA, HPC_SEL_DATA_INC: begin
          if (!st.op_read) begin
            next_st.req = '{valid: 1'b1, write: 1'b1, addr: st.addr,
                            wdata: st.wword};
            if (st.op_sel == HPC_SEL_DATA_INC) begin
              next_st.addr = st.addr + HPC_ADDR_STEP;
            end
          end else if (st.op_sel == HPC_SEL_DATA_INC) begin
            next_st.addr = st.addr + HPC_ADDR_STEP;
            next_st.req = '{valid: 1'b1, write: 1'b0,
                            addr: st.addr + HPC_ADDR_STEP,
                            wdata: HPC_WORD_ZERO};
          end
        end
        HPC_SEL_ADDR: begin
          if (!st.op_read) begin
            next_st.req = '{valid: 1'b1, write: 1'b0, addr: st.addr,
                            wdata: HPC_WORD_ZERO};
          end
        end
        default: begin
        end
      endcase
    end
    // Core raise wins over host clear
    if (core_irq_set) begin
      next_st.ctl_irq = 1'b1;
    end
    // Read data onto the bus
    case (sel)
      HPC_SEL_CTL: begin
        next_st.data_out = get_byte({13'h0000, st.ctl_irq, 2'h0}, pins.bil);
      end
      HPC_SEL_ADDR: begin
        next_st.data_out = get_byte(st.addr, pins.bil);
      end
      default: begin
        next_st.data_out = get_byte(st.rbuf, pins.bil);
      end
    endcase
    next_st.data_oe = rd_now && pins.emu_n;
    next_st.ready = next_st.enabled && !next_st.req.valid;
    next_st.rdy_oe = pins.emu_n;
    next_st.irq_oe = pins.emu_n;
    next_st.irq_pin = next_st.enabled ? !next_st.ctl_irq
                                      : timer_one_in;
    next_st.pull_en = !next_st.enabled;
  end

  // State register, reset drives interrupt pin high
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st <= HPC_STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign host_data_out = st.data_out;
  assign host_data_oe = st.data_oe;
  assign port_ready_out = st.ready;
  assign port_ready_oe = st.rdy_oe;
  assign host_irq_out = st.irq_pin;
  assign host_irq_oe = st.irq_oe;
  assign pullup_en = st.pull_en;
  assign port_enabled = st.enabled;
  assign core_req = st.req;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_irq_reset_high: assert property (
    @(posedge clk_sys) disable iff (1'b0)
    !rst_b ##1 !rst_b |-> host_irq_out && host_irq_oe)
    else $error("interrupt pin not high after reset cycle");
  a_timer_takes_pin: assert property (
    !st.enabled && !st.in_reset |=> host_irq_out == $past(timer_one_in))
    else $error("timer output not on interrupt pin");
  a_strap_capture: assert property (
    st.in_reset |=> port_enabled == $past(pins.strap))
    else $error("strap not captured at reset release");
  a_strap_ignored: assert property (
    !st.in_reset |=> $stable(port_enabled))
    else $error("enable changed after reset release");
  a_pullup_follow: assert property (
    !st.in_reset |-> pullup_en == !port_enabled)
    else $error("pull-up enable wrong for strap");
  a_float_on_emu: assert property (
    !pins.emu_n |=> !port_ready_oe && !host_irq_oe && !host_data_oe)
    else $error("pin driven while emulation-off low");
  a_data_float: assert property (
    host_data_oe |-> $past(rd_now))
    else $error("data bus driven outside a read");
  a_ready_busy: assert property (
    core_req.valid |-> !port_ready_out)
    else $error("ready high during internal transfer");
  a_ready_rise: assert property (
    $rose(port_ready_out) |-> $past(core_done) || $past(st.in_reset))
    else $error("ready rose without transfer completion");
  a_addr_latch: assert property (
    as_fall && pins.bil != HPC_BIL_FIRST && !stb_start
    |=> st.addr[7:0] == $past(pins.data))
    else $error("address byte not latched on address strobe");
  a_addr_write: assert property (
    stb_start && !rd_now && sel == HPC_SEL_ADDR &&
    pins.bil == HPC_BIL_FIRST |=> st.addr[15:8] == $past(pins.data))
    else $error("address high byte not written by strobe");

  c_core_write: cover property (core_req.valid && core_req.write);
  c_core_read: cover property (core_done && !core_req.write);
  c_timer_mode: cover property (!port_enabled && !st.in_reset);
  c_host_read: cover property (host_data_oe);
endmodule

// ==== inc/hpc_pkg.sv ====
// Shared types and constants for the host port pin control block.
// Assumes one core clock domain; all host pins are asynchronous to it.
package hpc_pkg;

  // Register select codes on {reg_select_hi, reg_select_lo}
  localparam logic [1:0] HPC_SEL_CTL = 2'h0;
  localparam logic [1:0] HPC_SEL_DATA_INC = 2'h1;
  localparam logic [1:0] HPC_SEL_ADDR = 2'h2;
  localparam logic [1:0] HPC_SEL_DATA = 2'h3;

  // Direction level meaning read
  localparam logic HPC_DIR_READ = 1'b1;
  // Byte half select level for the first (high) byte
  localparam logic HPC_BIL_FIRST = 1'b0;
  // Control word bit holding the host interrupt flag
  localparam int HPC_CTL_IRQ_BIT = 2;
  localparam logic [15:0] HPC_WORD_ZERO = 16'h0000;
  localparam logic [15:0] HPC_ADDR_STEP = 16'h0001;
  localparam logic [7:0] HPC_BYTE_ZERO = 8'h00;

  // Pin group as seen after synchronising
  typedef struct packed {
    logic cs_n;
    logic ds_a;
    logic ds_b;
    logic as_n;
    logic dir;
    logic sel_hi;
    logic sel_lo;
    logic bil;
    logic strap;
    logic emu_n;
    logic [7:0] data;
  } hpc_pins_t;

  // Request to the core memory side
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } hpc_req_t;

  // Whole state of the port
  typedef struct packed {
    logic in_reset;
    logic enabled;
    logic stb_d;
    logic as_d;
    logic [1:0] op_sel;
    logic op_read;
    logic op_bil;
    logic [7:0] wlatch;
    logic [15:0] wword;
    logic [15:0] addr;
    logic [15:0] rbuf;
    logic ctl_irq;
    hpc_req_t req;
    logic [7:0] data_out;
    logic data_oe;
    logic ready;
    logic rdy_oe;
    logic irq_pin;
    logic irq_oe;
    logic pull_en;
  } hpc_state_t;

  localparam hpc_state_t HPC_STATE_RST = '{
    in_reset: 1'b1, enabled: 1'b0, stb_d: 1'b0, as_d: 1'b1,
    op_sel: HPC_SEL_CTL, op_read: 1'b0, op_bil: 1'b0,
    wlatch: HPC_BYTE_ZERO, wword: HPC_WORD_ZERO, addr: HPC_WORD_ZERO,
    rbuf: HPC_WORD_ZERO, ctl_irq: 1'b0,
    req: '{valid: 1'b0, write: 1'b0, addr: HPC_WORD_ZERO,
           wdata: HPC_WORD_ZERO},
    data_out: HPC_BYTE_ZERO, data_oe: 1'b0, ready: 1'b0, rdy_oe: 1'b0,
    irq_pin: 1'b1, irq_oe: 1'b1, pull_en: 1'b0
  };

endpackage

// ==== hdl/hpc_sync.sv ====
// Two-stage synchroniser for a vector of asynchronous pins.
// Assumes each bit is used on its own; no multi-bit coherence given.
`timescale 1ns/1ps
module hpc_sync #(
  parameter int W = 8
) (
  input wire logic clk_sys,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hpc_sync_st_t;

  hpc_sync_st_t st;
  hpc_sync_st_t next_st;

  // First stage feeds only the second
  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  // No reset so strap levels pass through during reset
  always_ff @(posedge clk_sys) begin
    st <= next_st;
  end

  assign q = st.s2;
endmodule

// ==== verif/hpc_host.sv ====
// Host processor model: strobed byte accesses and address latching.
// Assumes the bench calls its tasks and feeds back the data pins.
`timescale 1ns/1ps
module hpc_host import hpc_pkg::*; (
  input wire logic clk_sys,
  input wire logic rdy,
  input wire logic dut_oe,
  input wire logic [7:0] dut_data,
  output logic cs_n,
  output logic stb_a,
  output logic stb_b,
  output logic as_n,
  output logic dir,
  output logic [1:0] sel,
  output logic bil,
  output logic [7:0] bus
);
  logic drv = 1'b0;
  logic [7:0] hd = 8'h00;
  // Bus level: host, then device, else a stray changing value
  assign bus = drv ? hd : (dut_oe ? dut_data : ~hd);
  // Idle pins
  initial begin
    {cs_n, stb_a, stb_b, as_n} = 4'hf;
    {dir, sel, bil} = 4'h0;
  end
  // One byte transfer once ready, strobe held for five clocks
  task automatic access(input logic [1:0] s, input logic d,
                        input logic b, input logic [7:0] w,
                        output logic [7:0] r);
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    #1;
    cs_n = 1'b0;
    sel = s;
    dir = d;
    bil = b;
    hd = w;
    drv = (d != HPC_DIR_READ);
    // First byte on one strobe, second on the other
    if (b) stb_b = 1'b0;
    else stb_a = 1'b0;
    repeat (5) @(posedge clk_sys);
    r = bus;
    #1;
    {stb_a, stb_b} = 2'h3;
    cs_n = 1'b1;
    drv = 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  // Multiplexed host presents one address byte
  task automatic latch_addr(input logic b, input logic [7:0] a);
    @(posedge clk_sys);
    #1;
    hd = a;
    drv = 1'b1;
    bil = b;
    as_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    as_n = 1'b1;
    drv = 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule

// ==== verif/tb_hpc_port.sv ====
// Testbench for the host port pin control block.
// Assumes the host model in hpc_host and a simple core memory model.
`timescale 1ns/1ps
module tb_hpc_port import hpc_pkg::*; ;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic strap_drv = 1'b1;
  tri0 strap_w;
  logic emu_float_n = 1'b1;
  logic timer_one_in = 1'b0;
  logic core_irq_set = 1'b0;
  logic core_done = 1'b0;
  logic [15:0] core_rdata = 16'h0000;
  logic [7:0] host_data_out, bus, r0;
  logic host_data_oe, port_ready_out, port_ready_oe, host_irq_out;
  logic host_irq_oe, pullup_en, port_enabled;
  logic cs_n, stb_a, stb_b, as_n, dir, bil, c_rdy;
  logic [1:0] sel;
  logic [15:0] c_addr, w_addr, c_wd;
  hpc_req_t core_req;
  int fails = 0;
  int samples_checked = 0;
  int n_req = 0;
  // Floating strap reads low through the pull-down
  assign strap_w = strap_drv;
  always #2.5 clk_sys = ~clk_sys;
  hpc_port i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .port_select_n(cs_n),
    .xfer_strobe_a(stb_a), .xfer_strobe_b(stb_b), .addr_latch_n(as_n),
    .xfer_direction(dir), .reg_select_lo(sel[0]), .reg_select_hi(sel[1]),
    .byte_half_select(bil), .host_data_in(bus),
    .port_enable_strap(strap_w), .emu_float_n(emu_float_n),
    .timer_one_in(timer_one_in), .core_irq_set(core_irq_set),
    .core_done(core_done), .core_rdata(core_rdata),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .port_ready_out(port_ready_out), .port_ready_oe(port_ready_oe),
    .host_irq_out(host_irq_out), .host_irq_oe(host_irq_oe),
    .pullup_en(pullup_en), .port_enabled(port_enabled),
    .core_req(core_req));
  hpc_host i_host (.clk_sys(clk_sys), .rdy(port_ready_out),
    .dut_oe(host_data_oe), .dut_data(host_data_out), .cs_n(cs_n),
    .stb_a(stb_a), .stb_b(stb_b), .as_n(as_n), .dir(dir), .sel(sel),
    .bil(bil), .bus(bus));
  // Core memory side: answers reads with the inverted address
  always begin
    @(posedge clk_sys);
    #1;
    if (core_req.valid === 1'b1) begin
      n_req++;
      c_rdy = port_ready_out;
      if (core_req.write) begin
        w_addr = core_req.addr;
        c_wd = core_req.wdata;
      end else begin
        c_addr = core_req.addr;
      end
      repeat (2) @(posedge clk_sys);
      #1;
      core_done = 1'b1;
      core_rdata = ~c_addr;
      @(posedge clk_sys);
      #1;
      core_done = 1'b0;
      core_rdata = ~core_rdata;
      @(posedge clk_sys);
    end
  end
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    while (port_ready_out !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    #1;
    // An enabled port must come back ready within the limit
    if (port_enabled === 1'b1) begin
      chk("ready back", 16'(port_ready_out), 16'h0001);
    end
  endtask
  task automatic rd_word(input logic [1:0] s, output logic [15:0] w);
    i_host.access(s, HPC_DIR_READ, HPC_BIL_FIRST, 8'h00, w[15:8]);
    i_host.access(s, HPC_DIR_READ, !HPC_BIL_FIRST, 8'h00, w[7:0]);
    wait_rdy();
  endtask
  task automatic wr_word(input logic [1:0] s, input logic [15:0] w);
    i_host.access(s, !HPC_DIR_READ, HPC_BIL_FIRST, w[15:8], r0);
    i_host.access(s, !HPC_DIR_READ, !HPC_BIL_FIRST, w[7:0], r0);
    wait_rdy();
  endtask
  task automatic do_reset(input logic s);
    rst_b = 1'b0;
    strap_drv = s;
    repeat (6) @(posedge clk_sys);
    #1;
    chk("irq pin in reset", 16'({host_irq_oe, host_irq_out}), 16'h0003);
    rst_b = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1;
    chk("enabled", 16'(port_enabled), 16'(s === 1'b1));
    chk("pullups", 16'(pullup_en), 16'(s !== 1'b1));
  endtask
  // Address write, data reads with and without increment, writes
  task automatic t_data();
    logic [15:0] w;
    int n;
    wr_word(HPC_SEL_ADDR, 16'h1234);
    chk("prefetch addr", c_addr, 16'h1234);
    chk("ready while busy", 16'(c_rdy), 16'h0000);
    n = n_req;
    rd_word(HPC_SEL_DATA, w);
    chk("read data", w, 16'hedcb);
    chk("no prefetch", 16'(n_req - n), 16'h0000);
    rd_word(HPC_SEL_DATA_INC, w);
    chk("inc read data", w, 16'hedcb);
    chk("inc prefetch", c_addr, 16'h1235);
    rd_word(HPC_SEL_DATA, w);
    chk("next data", w, 16'hedca);
    wr_word(HPC_SEL_DATA_INC, 16'habcd);
    chk("write addr", w_addr, 16'h1235);
    chk("write data", c_wd, 16'habcd);
    rd_word(HPC_SEL_ADDR, w);
    chk("addr after inc", w, 16'h1236);
  endtask
  task automatic t_latch();
    logic [15:0] w;
    i_host.latch_addr(HPC_BIL_FIRST, 8'h56);
    i_host.latch_addr(!HPC_BIL_FIRST, 8'h78);
    rd_word(HPC_SEL_ADDR, w);
    chk("latched addr", w, 16'h5678);
    // Plain data write: no address step afterwards
    wr_word(HPC_SEL_DATA, 16'h5aa5);
    chk("plain write addr", w_addr, 16'h5678);
    chk("plain write data", c_wd, 16'h5aa5);
    rd_word(HPC_SEL_ADDR, w);
    chk("addr kept", w, 16'h5678);
  endtask
  task automatic t_irq();
    logic [15:0] w;
    @(posedge clk_sys);
    #1;
    core_irq_set = 1'b1;
    @(posedge clk_sys);
    #1;
    core_irq_set = 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("irq raised", 16'(host_irq_out), 16'h0000);
    rd_word(HPC_SEL_CTL, w);
    chk("flag bit", 16'(w[HPC_CTL_IRQ_BIT]), 16'h0001);
    wr_word(HPC_SEL_CTL, 16'h0004);
    chk("irq cleared", 16'(host_irq_out), 16'h0001);
  endtask
  task automatic t_float();
    emu_float_n = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
    chk("floated", 16'({port_ready_oe, host_irq_oe, host_data_oe}),
        16'h0000);
    emu_float_n = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1;
    chk("driven", 16'({port_ready_oe, host_irq_oe}), 16'h0003);
  endtask
  task automatic t_disabled();
    int n;
    do_reset(1'bz);
    strap_drv = 1'b1;
    timer_one_in = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("timer high", 16'(host_irq_out), 16'h0001);
    timer_one_in = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("timer low", 16'(host_irq_out), 16'h0000);
    n = n_req;
    wr_word(HPC_SEL_ADDR, 16'h4321);
    chk("strap ignored", 16'(port_enabled), 16'h0000);
    chk("no request", 16'(n_req - n), 16'h0000);
  endtask
  // Main sequence
  initial begin
    do_reset(1'b1);
    t_data();
    t_latch();
    t_irq();
    t_float();
    t_disabled();
    complete_run();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    complete_run();
  end
endmodule
